// [logic/dtdp_pkg.sv]
// Constants, tables and types shared by the dual-tone dialer PWM block
// Operation
// - Pin index 0..15; only that pin driven
// - Pin output while busy, input afterwards
// - Tone on-time 0..65535 ms, default 200
// - Silent off-time 0..65535 ms, default 50
// - Codes played in order, gap between each
// - 4-bit codes: digits, star, pound, A-D
// - Two sines computed and summed digitally
// - Sum sets duty of fast PWM
package dtdp_pkg;

	// Clock and millisecond timing
	localparam int          CLK_HZ       = 40_000_000;
	localparam int          MS_PER_S     = 1000;
	localparam int          MS_TICKS_DEF = CLK_HZ / MS_PER_S;
	localparam int          TICK_W       = 16;

	// Widths of pins, codes and durations
	localparam int          PIN_N        = 16;
	localparam int          PIN_W        = 4;
	localparam int          CODE_W       = 4;
	localparam int          MS_W         = 16;
	localparam logic [15:0] ON_MS_DEF    = 16'h00C8;
	localparam logic [15:0] OFF_MS_DEF   = 16'h0032;

	// Tone code buffer
	localparam int          FIFO_DEPTH   = 8;
	localparam int          FIFO_CNT_W   = 4;

	// Register port and map
	localparam int          ADDR_W       = 8;
	localparam int          DATA_W       = 32;
	localparam logic [7:0]  REG_CTRL     = 8'h00;
	localparam logic [7:0]  REG_ON_MS    = 8'h04;
	localparam logic [7:0]  REG_OFF_MS   = 8'h08;
	localparam logic [7:0]  REG_TONE     = 8'h0C;
	localparam logic [7:0]  REG_STATUS   = 8'h10;

	// Control register fields
	localparam int          CTRL_START   = 0;
	localparam int          CTRL_PIN_LSB = 4;
	localparam int          CTRL_ON_DEF  = 8;
	localparam int          CTRL_OFF_DEF = 9;

	// Status register fields
	localparam int          ST_BUSY      = 0;
	localparam int          ST_TONE      = 1;
	localparam int          ST_EMPTY     = 2;
	localparam int          ST_FULL      = 3;
	localparam int          ST_OVF       = 4;
	localparam int          ST_CODE_LSB  = 8;
	localparam int          ST_CNT_LSB   = 16;

	// PWM frame and sample rate
	localparam int          PWM_W        = 9;
	localparam logic [8:0]  PWM_LAST     = 9'h1FF;
	localparam logic [8:0]  PWM_MID      = 9'h100;
	localparam int          SAMPLE_HZ    = CLK_HZ / 512;

	// Phase accumulators and quarter-wave sine table
	localparam int          ACC_W        = 24;
	localparam int          AMP_W        = 7;
	localparam logic [6:0]  SINE_Q [16]  = '{7'h06, 7'h13, 7'h1F, 7'h2B,
		7'h36, 7'h41, 7'h4C, 7'h55, 7'h5E, 7'h66, 7'h6D, 7'h73,
		7'h78, 7'h7B, 7'h7E, 7'h7F};

	// Increment per sample for a tone of hz, rounded
	function automatic logic [23:0] phase_inc(input int hz);
		longint t;
		t = ((longint'(hz) <<< ACC_W) + longint'(SAMPLE_HZ / 2))
			/ longint'(SAMPLE_HZ);
		return t[23:0];
	endfunction : phase_inc

	// Keypad grid frequencies
	localparam int          ROW_HZ [4]   = '{697, 770, 852, 941};
	localparam int          COL_HZ [4]   = '{1209, 1336, 1477, 1633};
	localparam logic [23:0] ROW_INC [4]  = '{phase_inc(697),
		phase_inc(770), phase_inc(852), phase_inc(941)};
	localparam logic [23:0] COL_INC [4]  = '{phase_inc(1209),
		phase_inc(1336), phase_inc(1477), phase_inc(1633)};

	// Code to keypad row and column: 0-9, star, pound, A-D
	localparam logic [1:0]  KEY_ROW [16] = '{2'h3, 2'h0, 2'h0, 2'h0,
		2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h3, 2'h3,
		2'h0, 2'h1, 2'h2, 2'h3};
	localparam logic [1:0]  KEY_COL [16] = '{2'h1, 2'h0, 2'h1, 2'h2,
		2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2, 2'h0, 2'h2,
		2'h3, 2'h3, 2'h3, 2'h3};

	// Sequencer states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_LOAD = 4'h2,
		ST_PLAY = 4'h4,
		ST_GAP  = 4'h8
	} dtdp_state_t;

endpackage : dtdp_pkg

// [logic/dtdp_fifo.sv]
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module dtdp_fifo #(
	parameter int WIDTH = 4,
	parameter int DEPTH = 8,
	parameter int CNT_W = 4
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             resetn,
	// Filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data,
	// Fill level
	output logic      [CNT_W-1:0] count
);

	localparam int PTR_W = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic             push;
	logic             pop;

	// Honest flags straight from the fill count
	assign in_ready  = (count != CNT_W'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Storage needs no reset; only pointers and the fill count carry state
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Pointers wrap at the depth
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
		end
	end

	// Fill count
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			count <= '0;
		end else if (push && !pop) begin
			count <= count + 1'b1;
		end else if (pop && !push) begin
			count <= count - 1'b1;
		end
	end

endmodule : dtdp_fifo

// [logic/dtdp_dialer.sv]
// Dual-tone dialer: register port, tone sequencer, synthesis and PWM pins
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module dtdp_dialer
	import dtdp_pkg::*;
#(
	parameter int MS_TICKS = MS_TICKS_DEF
) (
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              resetn,
	// Register port
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	// Pin drive, one output enable per pin
	output logic      [PIN_N-1:0]  pin_out,
	output logic      [PIN_N-1:0]  pin_oe,
	// Sequence status
	output logic                   busy
);

	// Sequencer state
	dtdp_state_t       state;
	dtdp_state_t       next_state;

	// Configuration
	logic [PIN_W-1:0]  pin_sel;
	logic [MS_W-1:0]   on_ms;
	logic [MS_W-1:0]   off_ms;
	logic              on_def;
	logic              off_def;
	logic              overflow;
	logic [PIN_W-1:0]  drive_pin;

	// Register decode
	logic              hit_ctrl;
	logic              hit_on;
	logic              hit_off;
	logic              hit_tone;
	logic              hit_status;
	logic              start_req;

	// Buffer handshake
	logic              fifo_in_ready;
	logic              fifo_out_valid;
	logic              fifo_out_ready;
	logic [CODE_W-1:0] fifo_out_data;
	logic [FIFO_CNT_W-1:0] fifo_count;

	// Timing
	logic [TICK_W-1:0] tick_cnt;
	logic              ms_tick;
	logic [MS_W-1:0]   ms_left;
	logic [MS_W-1:0]   on_len;
	logic [MS_W-1:0]   off_len;

	// Tone synthesis
	logic [CODE_W-1:0] cur_code;
	logic [ACC_W-1:0]  inc [2];
	logic [ACC_W-1:0]  acc [2];
	logic signed [AMP_W:0] wave [2];
	logic [PWM_W-1:0]  pwm_cnt;
	logic [PWM_W-1:0]  duty;
	logic [PWM_W-1:0]  next_duty;
	logic              sample_strobe;
	logic              pwm_high;
	logic              next_busy;

	// Address decode for both strobes
	always_comb begin
		hit_ctrl   = 1'b0;
		hit_on     = 1'b0;
		hit_off    = 1'b0;
		hit_tone   = 1'b0;
		hit_status = 1'b0;
		if (reg_addr == REG_CTRL) begin
			hit_ctrl = 1'b1;
		end else if (reg_addr == REG_ON_MS) begin
			hit_on = 1'b1;
		end else if (reg_addr == REG_OFF_MS) begin
			hit_off = 1'b1;
		end else if (reg_addr == REG_TONE) begin
			hit_tone = 1'b1;
		end else if (reg_addr == REG_STATUS) begin
			hit_status = 1'b1;
		end
	end

	// A start while a sequence runs is ignored, not queued
	assign start_req = reg_wr && hit_ctrl && reg_wdata[CTRL_START]
		&& !busy;
	// Pin of the start write itself, so no stale pin flashes at start
	assign drive_pin = start_req ? reg_wdata[CTRL_PIN_LSB +: PIN_W]
		: pin_sel;

	// Configuration freezes while busy so a running sequence stays coherent
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			pin_sel <= '0;
			on_def  <= 1'b1;
			off_def <= 1'b1;
		end else if (reg_wr && hit_ctrl && !busy) begin
			pin_sel <= reg_wdata[CTRL_PIN_LSB +: PIN_W];
			on_def  <= reg_wdata[CTRL_ON_DEF];
			off_def <= reg_wdata[CTRL_OFF_DEF];
		end
	end

	// Durations in milliseconds
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			on_ms  <= ON_MS_DEF;
			off_ms <= OFF_MS_DEF;
		end else if (reg_wr && !busy) begin
			if (hit_on) begin
				on_ms <= reg_wdata[MS_W-1:0];
			end
			if (hit_off) begin
				off_ms <= reg_wdata[MS_W-1:0];
			end
		end
	end

	// Default durations apply when the caller gives none
	assign on_len  = on_def ? ON_MS_DEF : on_ms;
	assign off_len = off_def ? OFF_MS_DEF : off_ms;

	// Lost push on a full buffer; new loss beats a clear in one cycle
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			overflow <= 1'b0;
		end else if (reg_wr && hit_tone && !fifo_in_ready) begin
			overflow <= 1'b1;
		end else if (reg_wr && hit_status && reg_wdata[ST_OVF]) begin
			overflow <= 1'b0;
		end
	end

	// Tone codes queue here in the order written
	dtdp_fifo #(
		.WIDTH (CODE_W),
		.DEPTH (FIFO_DEPTH),
		.CNT_W (FIFO_CNT_W)
	) u_code_fifo (
		.ref_clk   (ref_clk),
		.resetn    (resetn),
		.in_valid  (reg_wr && hit_tone),
		.in_ready  (fifo_in_ready),
		.in_data   (reg_wdata[CODE_W-1:0]),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data),
		.count     (fifo_count)
	);

	// Buffer drains only between tones, so it fills under a slow sequence
	assign fifo_out_ready = (state == ST_LOAD);

	// Millisecond tick, restarted on every state change
	assign ms_tick = (tick_cnt == TICK_W'(MS_TICKS - 1));

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			tick_cnt <= '0;
		end else if (next_state != state || ms_tick) begin
			tick_cnt <= '0;
		end else begin
			tick_cnt <= tick_cnt + 1'b1;
		end
	end

	// Sequencer transitions
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (start_req) begin
					next_state = ST_LOAD;
				end
			end
			ST_LOAD: begin
				if (fifo_out_valid) begin
					next_state = ST_PLAY;
				end else begin
					next_state = ST_IDLE;
				end
			end
			ST_PLAY: begin
				if (ms_left == '0) begin
					next_state = ST_GAP;
				end
			end
			ST_GAP: begin
				if (ms_left == '0) begin
					next_state = ST_LOAD;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Busy covers the last gap up to the empty-buffer check
	assign next_busy = (next_state != ST_IDLE);

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			busy <= 1'b0;
		end else begin
			busy <= next_busy;
		end
	end

	// Remaining whole milliseconds of the current tone or gap
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ms_left <= '0;
		end else if (state == ST_LOAD && fifo_out_valid) begin
			ms_left <= on_len;
		end else if (state == ST_PLAY && ms_left == '0) begin
			ms_left <= off_len;
		end else if (ms_tick && ms_left != '0) begin
			ms_left <= ms_left - 1'b1;
		end
	end

	// Code and grid increments latched as each tone starts
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			cur_code <= '0;
			inc[0]   <= '0;
			inc[1]   <= '0;
		end else if (state == ST_LOAD && fifo_out_valid) begin
			cur_code <= fifo_out_data;
			inc[0]   <= ROW_INC[KEY_ROW[fifo_out_data]];
			inc[1]   <= COL_INC[KEY_COL[fifo_out_data]];
		end
	end

	// PWM frame counter; one sample per frame
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			pwm_cnt <= '0;
		end else begin
			pwm_cnt <= pwm_cnt + 1'b1;
		end
	end

	assign sample_strobe = (pwm_cnt == PWM_LAST);

	// Two oscillators, each a phase accumulator and quarter-wave lookup
	for (genvar k = 0; k < 2; k++) begin : g_osc
		logic [5:0] ph;
		logic [3:0] idx;
		logic [6:0] mag;

		// Phase restarts at zero so every tone opens cleanly
		always_ff @(posedge ref_clk) begin
			if (!resetn) begin
				acc[k] <= '0;
			end else if (state != ST_PLAY) begin
				acc[k] <= '0;
			end else if (sample_strobe) begin
				acc[k] <= acc[k] + inc[k];
			end
		end

		// Mirror the index in odd quarters, negate in the second half
		assign ph  = acc[k][ACC_W-1 -: 6];
		assign idx = ph[4] ? ~ph[3:0] : ph[3:0];
		assign mag = SINE_Q[idx];
		assign wave[k] = ph[5] ? -$signed({1'b0, mag})
			: $signed({1'b0, mag});
	end

	// Sum of both sines offset to mid-scale; peak 254 stays inside 0..511
	always_comb begin
		logic signed [PWM_W+1:0] mix;
		mix = '0;
		mix = $signed({2'b00, PWM_MID}) + (PWM_W+2)'(wave[0])
			+ (PWM_W+2)'(wave[1]);
		if (state == ST_PLAY) begin
			next_duty = mix[PWM_W-1:0];
		end else begin
			next_duty = PWM_MID;
		end
	end

	// Duty changes only at a frame edge to avoid runt pulses
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			duty <= PWM_MID;
		end else if (sample_strobe) begin
			duty <= next_duty;
		end
	end

	// 78 kHz pulse rate, far above the keypad band
	assign pwm_high = (pwm_cnt < duty);

	// Per-pin drive; the gap idles at half duty, which filters to silence
	for (genvar i = 0; i < PIN_N; i++) begin : g_pin
		always_ff @(posedge ref_clk) begin
			if (!resetn) begin
				pin_oe[i]  <= 1'b0;
				pin_out[i] <= 1'b0;
			end else if (next_busy && drive_pin == PIN_W'(i)) begin
				pin_oe[i]  <= 1'b1;
				pin_out[i] <= pwm_high;
			end else begin
				pin_oe[i]  <= 1'b0;
				pin_out[i] <= 1'b0;
			end
		end
	end

	// Read data stands only in the cycle after the read strobe
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			reg_rdata <= '0;
		end else if (!reg_rd) begin
			reg_rdata <= '0;
		end else if (hit_ctrl) begin
			reg_rdata <= '0;
			reg_rdata[CTRL_PIN_LSB +: PIN_W] <= pin_sel;
			reg_rdata[CTRL_ON_DEF]           <= on_def;
			reg_rdata[CTRL_OFF_DEF]          <= off_def;
		end else if (hit_on) begin
			reg_rdata <= {{(DATA_W-MS_W){1'b0}}, on_ms};
		end else if (hit_off) begin
			reg_rdata <= {{(DATA_W-MS_W){1'b0}}, off_ms};
		end else if (hit_status) begin
			reg_rdata <= '0;
			reg_rdata[ST_BUSY]                       <= busy;
			reg_rdata[ST_TONE]                       <= (state == ST_PLAY);
			reg_rdata[ST_EMPTY]                      <= !fifo_out_valid;
			reg_rdata[ST_FULL]                       <= !fifo_in_ready;
			reg_rdata[ST_OVF]                        <= overflow;
			reg_rdata[ST_CODE_LSB +: CODE_W]         <= cur_code;
			reg_rdata[ST_CNT_LSB +: FIFO_CNT_W]      <= fifo_count;
		end else begin
			reg_rdata <= '0;
		end
	end

endmodule : dtdp_dialer

// [testbench/dtdp_dialer_assertions.sv]
// Port-level checker for the dual-tone dialer, bound to its top module
`timescale 1ns/1ps
module dtdp_dialer_checker
	import dtdp_pkg::*;
#(
	parameter int MS_TICKS = MS_TICKS_DEF
) (
	// Clock and reset
	input wire logic              ref_clk,
	input wire logic              resetn,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	// Pins and status
	input wire logic [PIN_N-1:0]  pin_out,
	input wire logic [PIN_N-1:0]  pin_oe,
	input wire logic              busy
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	// Start written while idle
	sequence idle_start;
		!busy && reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_START];
	endsequence

	// Two running cycles in a row
	sequence run_two;
		busy ##1 busy;
	endsequence

	oe_onehot_a: assert property ($onehot0(pin_oe))
		else $error("more than one pin enabled");
	out_gated_a: assert property ((pin_out & ~pin_oe) == '0)
		else $error("drive on a pin that is not enabled");
	oe_busy_a: assert property ((pin_oe != '0) == busy)
		else $error("pin direction disagrees with busy");
	start_pin_a: assert property (
		idle_start |=> busy && pin_oe == (16'h0001 << $past(reg_wdata[7:4])))
		else $error("start did not enable the chosen pin");
	busy_cause_a: assert property ($rose(busy) |->
		$past(reg_wr) && $past(reg_addr) == REG_CTRL && $past(reg_wdata[0]))
		else $error("busy rose without a start write");
	oe_hold_a: assert property (run_two |-> $stable(pin_oe))
		else $error("pin changed during a sequence");
	idle_clean_a: assert property (
		$fell(busy) |-> pin_oe == '0 && pin_out == '0)
		else $error("pin left driven after the sequence");
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
		else $error("read data outside its cycle");

	cov_start_c: cover property (idle_start ##1 run_two);
endmodule : dtdp_dialer_checker

bind dtdp_dialer dtdp_dialer_checker #(.MS_TICKS(MS_TICKS)) u_chk (
	.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .pin_out(pin_out), .pin_oe(pin_oe),
	.busy(busy));

// [testbench/dtdp_filter_model.sv]
// Far-side model: low-pass filter reduced to a one-frame moving sum
`timescale 1ns/1ps
module dtdp_filter_model
	import dtdp_pkg::*;
(
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             resetn,
	// Dialer pins and the one wired to the filter
	input  wire logic [PIN_N-1:0] pin_out,
	input  wire logic [PIN_N-1:0] pin_oe,
	input  wire logic [PIN_W-1:0] sel,
	// Recovered audio level, 256 means silence
	output logic      [9:0]       level
);
	logic [511:0] hist;
	logic         line;

	// Pull-down at the filter input reads a released pin as low
	assign line = pin_oe[sel] ? pin_out[sel] : 1'b0;

	// A 512-cycle window averages any frame phase, so a flat duty is exact
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			hist  <= '0;
			level <= '0;
		end else begin
			hist  <= {hist[510:0], line};
			level <= level + {9'h000, line} - {9'h000, hist[511]};
		end
	end
endmodule : dtdp_filter_model

// [testbench/tb.sv]
// Self-checking bench for the dual-tone dialer
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
	import dtdp_pkg::*;
	localparam int M = 8;
	logic        ref_clk, resetn, reg_wr, reg_rd, busy;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic [15:0] pin_out, pin_oe;
	logic [3:0]  sel;
	logic [9:0]  level, lvl_max, lvl_gap;
	logic        prev, clr;
	int          errors, compares, busy_cyc, k;
	logic [7:0]  ra [6] = '{REG_CTRL, REG_ON_MS, REG_OFF_MS, REG_TONE,
		REG_STATUS, 8'h14};
	logic [31:0] rv [6] = '{32'h300, 32'hC8, 32'h32, 32'h0, 32'h4, 32'h0};

	dtdp_dialer #(.MS_TICKS(M)) u_dtdp_dialer (.ref_clk(ref_clk),
		.resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pin_out(pin_out), .pin_oe(pin_oe), .busy(busy));
	dtdp_filter_model u_dtdp_filter_model (.ref_clk(ref_clk),
		.resetn(resetn), .pin_out(pin_out), .pin_oe(pin_oe), .sel(sel),
		.level(level));

	// Clock at 40 MHz
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// Running length and filter level while busy
	always @(posedge ref_clk) begin
		if (clr) begin
			busy_cyc <= 0;
			lvl_max  <= '0;
			lvl_gap  <= '0;
		end else if (busy === 1'b1) begin
			busy_cyc <= busy_cyc + 1;
			lvl_gap  <= level;
			if (level > lvl_max) lvl_max <= level;
		end
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask : wr

	// Data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
		@(posedge ref_clk);
	endtask : rd

	task automatic wait_idle();
		for (int i = 0; i < 40000 && busy !== 1'b0; i++) @(posedge ref_clk);
		`CHK(busy, 1'b0)
	endtask : wait_idle

	// Statistics restart; one edge so the counting process does it alone
	task automatic clear_stats();
		clr <= 1'b1;
		@(posedge ref_clk);
		clr <= 1'b0;
	endtask : clear_stats

	// First load, then per tone the on-time, the gap and one load, each +1
	task automatic check_len(input int n, input int on, input int off);
		int exp;
		exp = 1 + n * ((on + off) * M + 3);
		`CHK(busy_cyc, exp)
	endtask : check_len

	task automatic give_verdict();
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict

	// Watchdog sized well beyond the longest run
	initial begin
		#(25 * 80000);
		errors++;
		give_verdict();
	end

	initial begin
		{reg_wr, reg_rd, reg_addr, reg_wdata, resetn, sel} = '0;
		{errors, compares} = '0;
		clr = 1'b1;
		repeat (5) @(posedge ref_clk);
		resetn <= 1'b1;
		clr    <= 1'b0;
		@(posedge ref_clk);
		// Reset values and an unmapped place
		wr(8'h14, 32'hFFFFFFFF);
		for (int i = 0; i < 6; i++) begin
			rd(ra[i], d);
			`CHK(d, rv[i])
		end
		// Every pin with zero durations
		wr(REG_ON_MS, 32'h0);
		wr(REG_OFF_MS, 32'h0);
		for (int p = 0; p < 16; p++) begin
			wr(REG_TONE, 32'(p));
			wr(REG_CTRL, 32'h1 | 32'(p << 4));
			#1 `CHK(pin_oe, 16'h1 << p)
			wait_idle();
			`CHK(pin_oe, 16'h0)
		end
		// All sixteen codes in order, with overflow on the first batch
		wr(REG_ON_MS, 32'h1);
		wr(REG_OFF_MS, 32'h1);
		for (int b = 0; b < 2; b++) begin
			for (int i = 0; i < 8; i++) wr(REG_TONE, 32'(b * 8 + i));
			if (b == 0) begin
				wr(REG_TONE, 32'hF);
				rd(REG_STATUS, d);
				`CHK(d & 32'hF001E, 32'h80018)
				wr(REG_STATUS, 32'h10);
				rd(REG_STATUS, d);
				`CHK(d & 32'hF001E, 32'h80008)
			end
			wr(REG_CTRL, 32'h1);
			prev = 1'b0;
			k = 0;
			for (int j = 0; j < 200; j++) begin
				rd(REG_STATUS, d);
				if (d[ST_TONE] && !prev) begin
					`CHK(d[11:8], 4'(b * 8 + k))
					k++;
				end
				prev = d[ST_TONE];
				if (d[ST_BUSY] === 1'b0) break;
			end
			`CHK(k, 8)
		end
		// Default times; a second start and a new on-time while busy are ignored
		wr(REG_TONE, 32'h5);
		clear_stats();
		wr(REG_CTRL, 32'h331);
		wr(REG_CTRL, 32'h071);
		wr(REG_ON_MS, 32'h5);
		`CHK(pin_oe, 16'h0008)
		rd(REG_ON_MS, d);
		`CHK(d, 32'h1)
		wait_idle();
		check_len(1, 200, 50);
		// Start with nothing queued
		clear_stats();
		wr(REG_CTRL, 32'h1);
		wait_idle();
		`CHK(busy_cyc, 1)
		// Long tone then long gap seen through the filter
		wr(REG_ON_MS, 32'd2000);
		wr(REG_OFF_MS, 32'd200);
		wr(REG_TONE, 32'h1);
		clear_stats();
		wr(REG_CTRL, 32'h1);
		wait_idle();
		check_len(1, 2000, 200);
		`CHK(lvl_gap, 10'd256)
		`CHK(lvl_max > 10'd296, 1'b1)
		give_verdict();
	end
endmodule : tb
